// file: rtl/sdil_irq_ctrl.sv
// Purpose: interrupt detection, masking, stacking and reporting toward the host
// Assumes: event, status and direction inputs come from core logic on clk_sys
// Notes:   register port answers every access at once; read data one cycle later
//
// Design decisions made here: the register offsets and the plain strobed port.
`timescale 1ns/1ns
module sdil_irq_ctrl
   import sdil_pkg::*;
(
   // clock and reset
   input  wire logic                        clk_sys,
   input  wire logic                        resetn,
   // register port
   input  wire logic [SDIL_AW-1:0]          reg_addr,
   input  wire logic [SDIL_DW-1:0]          reg_wdata,
   input  wire logic                        reg_wr,
   input  wire logic                        reg_rd,
   output logic      [SDIL_DW-1:0]          reg_rdata,
   // cause events from the core, one-cycle pulses
   input  wire logic [7:0]                  bus_evt_a,
   input  wire logic [7:0]                  bus_evt_b,
   input  wire logic [SDIL_DMA_CAUSE_W-1:0] dma_evt,
   input  wire logic                        on_fly_evt,
   // core status
   input  wire logic                        script_running,
   input  wire logic                        bus_receiving,
   input  wire logic                        dma_fifo_empty,
   // toward host and core
   output logic                             irq_n,
   output logic                             script_halt,
   output logic                             dma_fifo_drain,
   output logic                             dma_fifo_clear,
   output logic                             dma_fifo_flush,
   output logic                             bus_fifo_clear
);

   // ****************************************
   // declarations
   // ****************************************
   logic [7:0]                  mask_a_q;
   logic [7:0]                  mask_b_q;
   logic [SDIL_DMA_CAUSE_W-1:0] dma_mask_q;
   logic [7:0]                  mode_q;
   logic                        on_fly_q;
   logic                        irq_n_q;
   logic                        halt_q;
   logic                        drain_q;
   logic                        dclr_q;
   logic                        dflush_q;
   logic                        bclr_q;
   logic [SDIL_DW-1:0]          rdata_q;
   logic [7:0]                  hold_a_q;
   logic [7:0]                  hold_b_q;
   logic [7:0]                  vis_a;
   logic [7:0]                  vis_b;
   logic [SDIL_DMA_CAUSE_W-1:0] vis_d;
   logic                        wr_dtest;
   logic                        wr_btest;
   logic [7:0]                  nonfatal_a;
   logic [7:0]                  report_a;
   logic [7:0]                  report_b;
   logic [7:0]                  defer_a;
   logic [7:0]                  defer_b;
   logic [7:0]                  post_a;
   logic [7:0]                  post_b;
   logic                        bus_pend;
   logic                        dma_pend;
   logic                        any_pend;
   logic                        promote;
   logic                        acc_ok;
   logic                        wr_ok;
   logic                        rd_ok;
   logic                        rd_a;
   logic                        rd_b;
   logic                        rd_dma;
   logic                        irq_cause;
   logic [SDIL_DW-1:0]          rd_mux;

   // ****************************************
   // access decode
   // ****************************************
   // the summary register stays reachable so software can poll a running engine
   assign acc_ok = !script_running || (reg_addr == SDIL_OFS_SUMMARY);
   assign wr_ok  = reg_wr && acc_ok;
   assign rd_ok  = reg_rd && acc_ok;
   assign rd_a   = rd_ok && (reg_addr == SDIL_OFS_CAUSE_A);
   assign rd_b   = rd_ok && (reg_addr == SDIL_OFS_CAUSE_B);
   assign rd_dma = rd_ok && (reg_addr == SDIL_OFS_DMA_CAUSE);
   assign wr_dtest = wr_ok && (reg_addr == SDIL_OFS_DMA_TEST);
   assign wr_btest = wr_ok && (reg_addr == SDIL_OFS_BUS_TEST);

   // ****************************************
   // classification
   // ****************************************
   always_comb begin
      nonfatal_a = 8'h00;
      nonfatal_a[SDIL_A_FUNC_DONE] = 1'b1;
      nonfatal_a[SDIL_A_SELECTED]  = 1'b1;
      if (mode_q[SDIL_MODE_TARGET]) begin
         nonfatal_a[SDIL_A_ATTENTION] = 1'b1;
      end else begin
         nonfatal_a[SDIL_A_RESELECTED] = 1'b1;
      end
   end

   // fatal bits report even when masked; register b holds only fatal causes
   assign report_a = mask_a_q | ~nonfatal_a;
   assign report_b = 8'hFF;

   // ****************************************
   // deferral while the dma fifo drains
   // ****************************************
   // a fatal receive error must not post before received data reach memory
   assign defer_a = (bus_receiving && !dma_fifo_empty) ? (bus_evt_a & ~nonfatal_a) : 8'h00;
   assign defer_b = (bus_receiving && !dma_fifo_empty) ? bus_evt_b : 8'h00;
   assign post_a  = (bus_evt_a & ~defer_a) | (dma_fifo_empty ? hold_a_q : 8'h00);
   assign post_b  = (bus_evt_b & ~defer_b) | (dma_fifo_empty ? hold_b_q : 8'h00);

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         hold_a_q <= 8'h00;
         hold_b_q <= 8'h00;
         drain_q  <= 1'b0;
      end else begin
         hold_a_q <= dma_fifo_empty ? 8'h00 : (hold_a_q | defer_a);
         hold_b_q <= dma_fifo_empty ? 8'h00 : (hold_b_q | defer_b);
         drain_q  <= !dma_fifo_empty && ((|(hold_a_q | defer_a)) || (|(hold_b_q | defer_b)));
      end
   end

   // ****************************************
   // pending flags and stacking
   // ****************************************
   assign bus_pend = (|(vis_a & report_a)) || (|(vis_b & report_b));
   assign dma_pend = |vis_d;
   assign any_pend = bus_pend || dma_pend;
   assign promote  = !any_pend;

   sdil_stack_reg #(.W(8)) u_cause_a (
      .clk_sys   (clk_sys),
      .resetn    (resetn),
      .set_bits  (post_a),
      .stack_en  (any_pend),
      .clr_en    (rd_a),
      .clr_bits  (vis_a),
      .promote   (promote),
      .visible_q (vis_a),
      .shadow_q  ()
   );

   sdil_stack_reg #(.W(8)) u_cause_b (
      .clk_sys   (clk_sys),
      .resetn    (resetn),
      .set_bits  (post_b),
      .stack_en  (any_pend),
      .clr_en    (rd_b),
      .clr_bits  (vis_b),
      .promote   (promote),
      .visible_q (vis_b),
      .shadow_q  ()
   );

   // dma causes post at once: no fifo flush precedes them
   sdil_stack_reg #(.W(SDIL_DMA_CAUSE_W)) u_cause_dma (
      .clk_sys   (clk_sys),
      .resetn    (resetn),
      .set_bits  (dma_evt),
      .stack_en  (any_pend),
      .clr_en    (rd_dma),
      .clr_bits  (vis_d),
      .promote   (promote),
      .visible_q (vis_d),
      .shadow_q  ()
   );

   // ****************************************
   // on-the-fly flag
   // ****************************************
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         on_fly_q <= 1'b0;
      end else if (on_fly_evt) begin
         on_fly_q <= 1'b1;
      end else if (wr_ok && (reg_addr == SDIL_OFS_SUMMARY) && reg_wdata[SDIL_SUM_ON_FLY]) begin
         on_fly_q <= 1'b0;
      end
   end

   // ****************************************
   // interrupt request and halt
   // ****************************************
   assign irq_cause = (|(vis_a & mask_a_q)) || (|(vis_b & mask_b_q)) ||
                      (|(vis_d & dma_mask_q)) || on_fly_q;

   // once raised, unmasking cannot drop it; it falls only when no group is pending and the on-the-fly flag is clear
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         irq_n_q <= 1'b1;
      end else begin
         irq_n_q <= !(irq_cause || (!irq_n_q && (any_pend || on_fly_q)));
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         halt_q <= 1'b0;
      end else begin
         halt_q <= (|(post_a & report_a)) ||
                   (|post_b) ||
                   (|dma_evt);
      end
   end

   // ****************************************
   // configuration registers
   // ****************************************
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         mask_a_q   <= SDIL_RST_MASK;
         mask_b_q   <= SDIL_RST_MASK;
         dma_mask_q <= SDIL_RST_MASK[SDIL_DMA_CAUSE_W-1:0];
         mode_q     <= SDIL_RST_MODE;
      end else if (wr_ok) begin
         unique case (reg_addr)
            SDIL_OFS_MASK_A:   mask_a_q   <= reg_wdata;
            SDIL_OFS_MASK_B:   mask_b_q   <= reg_wdata;
            SDIL_OFS_DMA_MASK: dma_mask_q <= reg_wdata[SDIL_DMA_CAUSE_W-1:0];
            SDIL_OFS_MODE:     mode_q     <= reg_wdata;
            default: begin
            end
         endcase
      end
   end

   // ****************************************
   // fifo control strobes
   // ****************************************
   // self-clearing: software sees them read back as zero
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         dclr_q   <= 1'b0;
         dflush_q <= 1'b0;
         bclr_q   <= 1'b0;
      end else begin
         dclr_q   <= wr_dtest && reg_wdata[SDIL_DT_FIFO_CLEAR];
         dflush_q <= wr_dtest && reg_wdata[SDIL_DT_FIFO_FLUSH];
         bclr_q   <= wr_btest && reg_wdata[SDIL_BT_FIFO_CLEAR];
      end
   end

   // ****************************************
   // read data
   // ****************************************
   always_comb begin
      rd_mux = 8'h00;
      unique case (reg_addr)
         SDIL_OFS_SUMMARY: begin
            rd_mux[SDIL_SUM_DMA_PEND] = dma_pend;
            rd_mux[SDIL_SUM_BUS_PEND] = bus_pend;
            rd_mux[SDIL_SUM_ON_FLY]   = on_fly_q;
         end
         SDIL_OFS_CAUSE_A:  rd_mux = vis_a;
         SDIL_OFS_CAUSE_B:  rd_mux = vis_b;
         SDIL_OFS_DMA_CAUSE: begin
            rd_mux[SDIL_DMA_CAUSE_W-1:0] = vis_d;
            rd_mux[SDIL_DMA_FIFO_EMPTY]  = dma_fifo_empty;
         end
         SDIL_OFS_MASK_A:   rd_mux = mask_a_q;
         SDIL_OFS_MASK_B:   rd_mux = mask_b_q;
         SDIL_OFS_DMA_MASK: rd_mux[SDIL_DMA_CAUSE_W-1:0] = dma_mask_q;
         SDIL_OFS_MODE:     rd_mux = mode_q;
         default:           rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         rdata_q <= SDIL_RST_RDATA;
      end else if (rd_ok) begin
         rdata_q <= rd_mux;
      end else begin
         rdata_q <= 8'h00;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign reg_rdata      = rdata_q;
   assign irq_n          = irq_n_q;
   assign script_halt    = halt_q;
   assign dma_fifo_drain = drain_q;
   assign dma_fifo_clear = dclr_q;
   assign dma_fifo_flush = dflush_q;
   assign bus_fifo_clear = bclr_q;

endmodule : sdil_irq_ctrl

// file: rtl/sdil_pkg.sv
// Purpose: shared constants of the interrupt detection and reporting block
// Assumes: 8-bit register port, byte-wide registers at byte offsets
// Notes:   all bit positions and offsets are named here once
package sdil_pkg;

   // ****************************************
   // register port
   // ****************************************
   localparam int unsigned SDIL_AW = 8;
   localparam int unsigned SDIL_DW = 8;

   // ****************************************
   // register offsets
   // ****************************************
   localparam logic [7:0] SDIL_OFS_SUMMARY  = 8'h00;
   localparam logic [7:0] SDIL_OFS_CAUSE_A  = 8'h01;
   localparam logic [7:0] SDIL_OFS_CAUSE_B  = 8'h02;
   localparam logic [7:0] SDIL_OFS_MASK_A   = 8'h04;
   localparam logic [7:0] SDIL_OFS_MASK_B   = 8'h05;
   localparam logic [7:0] SDIL_OFS_DMA_MASK = 8'h06;
   localparam logic [7:0] SDIL_OFS_DMA_TEST = 8'h07;
   localparam logic [7:0] SDIL_OFS_BUS_TEST = 8'h08;
   localparam logic [7:0] SDIL_OFS_MODE     = 8'h09;
   localparam logic [7:0] SDIL_OFS_DMA_CAUSE = 8'h0C;

   // ****************************************
   // field positions
   // ****************************************
   localparam int unsigned SDIL_SUM_DMA_PEND = 0;
   localparam int unsigned SDIL_SUM_BUS_PEND = 1;
   localparam int unsigned SDIL_SUM_ON_FLY   = 2;
   localparam int unsigned SDIL_A_RESELECTED = 4;
   localparam int unsigned SDIL_A_SELECTED   = 5;
   localparam int unsigned SDIL_A_FUNC_DONE  = 6;
   localparam int unsigned SDIL_A_ATTENTION  = 7;
   localparam int unsigned SDIL_DMA_FIFO_EMPTY = 7;
   localparam int unsigned SDIL_DMA_CAUSE_W  = 7;
   localparam int unsigned SDIL_DT_FIFO_CLEAR = 2;
   localparam int unsigned SDIL_DT_FIFO_FLUSH = 3;
   localparam int unsigned SDIL_BT_FIFO_CLEAR = 1;
   localparam int unsigned SDIL_MODE_TARGET  = 0;

   // ****************************************
   // reset values
   // ****************************************
   localparam logic [7:0] SDIL_RST_MASK     = 8'h00;
   localparam logic [7:0] SDIL_RST_MODE     = 8'h00;
   localparam logic [7:0] SDIL_RST_RDATA    = 8'h00;

endpackage : sdil_pkg

// file: rtl/sdil_stack_reg.sv
// Purpose: one cause register with a visible level and a shadow level
// Assumes: set, clear and promote come from logic on clk_sys
// Notes:   a set in the cycle of a clear survives; a set while stack_en is high goes to the shadow level
`timescale 1ns/1ns
module sdil_stack_reg #(
   parameter int unsigned W = 8
) (
   // clock and reset
   input  wire logic         clk_sys,
   input  wire logic         resetn,
   // control
   input  wire logic [W-1:0] set_bits,
   input  wire logic         stack_en,
   input  wire logic         clr_en,
   input  wire logic [W-1:0] clr_bits,
   input  wire logic         promote,
   // state
   output logic      [W-1:0] visible_q,
   output logic      [W-1:0] shadow_q
);

   logic [W-1:0] vis_d;
   logic [W-1:0] shd_d;

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      vis_d = visible_q;
      shd_d = shadow_q;
      if (clr_en) begin
         vis_d = vis_d & ~clr_bits;
      end
      if (promote) begin
         vis_d = vis_d | shadow_q;
         shd_d = '0;
      end
      if (stack_en) begin
         shd_d = shd_d | set_bits;
      end else begin
         vis_d = vis_d | set_bits;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         visible_q <= '0;
         shadow_q  <= '0;
      end else begin
         visible_q <= vis_d;
         shadow_q  <= shd_d;
      end
   end

endmodule : sdil_stack_reg

// file: verif/sdil_host_model.sv
// Purpose: host processor driving the register port
// Assumes: strobes one cycle long, read data sampled in the slot after the read
// Notes:   address and data are inverted once released so stale values never match
`timescale 1ns/1ns
module sdil_host_model
   import sdil_pkg::*;
(
   // clock
   input  wire logic               clk_sys,
   // register port
   output logic      [SDIL_AW-1:0] reg_addr,
   output logic      [SDIL_DW-1:0] reg_wdata,
   output logic                    reg_wr,
   output logic                    reg_rd,
   input  wire logic [SDIL_DW-1:0] reg_rdata
);
   initial begin
      reg_addr  = 8'h00;
      reg_wdata = 8'h00;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
   end

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk_sys);
      reg_wr    <= 1'b0;
      reg_addr  <= ~a;
      reg_wdata <= ~d;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk_sys);
      reg_rd   <= 1'b0;
      reg_addr <= ~a;
      #1 d = reg_rdata;
   endtask : rd

   // on-the-fly first, then leftover dma fifo data is discarded
   task automatic service(output logic [7:0] s);
      logic [7:0] d;
      rd(SDIL_OFS_SUMMARY, s);
      if (s[SDIL_SUM_ON_FLY]) wr(SDIL_OFS_SUMMARY, 8'h04);
      if (s[SDIL_SUM_DMA_PEND]) begin
         rd(SDIL_OFS_DMA_CAUSE, d);
         if (!d[SDIL_DMA_FIFO_EMPTY]) begin
            wr(SDIL_OFS_DMA_TEST, 8'h04);
            wr(SDIL_OFS_BUS_TEST, 8'h02);
         end
      end
   endtask : service
endmodule : sdil_host_model

// file: verif/sdil_irq_assertions.sv
// Purpose: port-level checks of the interrupt controller
// Assumes: bound to sdil_irq_ctrl, single clock, sync active-low reset
// Notes:   masks are not visible here, so only mask-free relations are checked
`timescale 1ns/1ns
module sdil_irq_assertions
   import sdil_pkg::*;
(
   // clock and reset
   input wire logic                        clk_sys,
   input wire logic                        resetn,
   // register port
   input wire logic [SDIL_AW-1:0]          reg_addr,
   input wire logic [SDIL_DW-1:0]          reg_wdata,
   input wire logic                        reg_wr,
   input wire logic                        reg_rd,
   input wire logic [SDIL_DW-1:0]          reg_rdata,
   // core side
   input wire logic [7:0]                  bus_evt_b,
   input wire logic [SDIL_DMA_CAUSE_W-1:0] dma_evt,
   input wire logic                        script_running,
   input wire logic                        bus_receiving,
   input wire logic                        dma_fifo_empty,
   input wire logic                        irq_n,
   input wire logic                        script_halt,
   input wire logic                        dma_fifo_drain,
   input wire logic                        dma_fifo_clear,
   input wire logic                        dma_fifo_flush,
   input wire logic                        bus_fifo_clear
);
   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   logic wr_ok;
   assign wr_ok = reg_wr && !script_running;

   a_refused_read: assert property (
      reg_rd && script_running && reg_addr != SDIL_OFS_SUMMARY |=> reg_rdata == 8'h00)
      else $error("refused read returned data");
   a_empty_live: assert property (
      reg_rd && !script_running && reg_addr == SDIL_OFS_DMA_CAUSE
      |=> reg_rdata[SDIL_DMA_FIFO_EMPTY] == $past(dma_fifo_empty))
      else $error("fifo empty bit not live");
   a_dma_halt: assert property (dma_evt != 0 |=> script_halt)
      else $error("dma cause did not halt");
   a_drain_hold: assert property (
      bus_receiving && !dma_fifo_empty && bus_evt_b != 8'h00 |=> dma_fifo_drain)
      else $error("fatal receive cause not held for drain");
   a_dma_clr: assert property (
      wr_ok && reg_addr == SDIL_OFS_DMA_TEST && reg_wdata[SDIL_DT_FIFO_CLEAR] |=> dma_fifo_clear)
      else $error("dma fifo clear missing");
   a_dma_flush: assert property (
      wr_ok && reg_addr == SDIL_OFS_DMA_TEST && reg_wdata[SDIL_DT_FIFO_FLUSH] |=> dma_fifo_flush)
      else $error("dma fifo flush missing");
   a_bus_clr: assert property (
      wr_ok && reg_addr == SDIL_OFS_BUS_TEST && reg_wdata[SDIL_BT_FIFO_CLEAR] |=> bus_fifo_clear)
      else $error("bus fifo clear missing");
   a_fifo_cause: assert property (
      dma_fifo_clear || dma_fifo_flush |-> $past(reg_wr) && $past(reg_addr) == SDIL_OFS_DMA_TEST)
      else $error("fifo action without host write");
   a_irq_hold: assert property (
      $rose(irq_n) |-> $past(reg_rd) || $past(reg_wr) || $past(reg_rd, 2) || $past(reg_wr, 2))
      else $error("request dropped without host access");
endmodule : sdil_irq_assertions

bind sdil_irq_ctrl sdil_irq_assertions u_chk (
   .clk_sys, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .bus_evt_b,
   .dma_evt, .script_running, .bus_receiving, .dma_fifo_empty, .irq_n, .script_halt,
   .dma_fifo_drain, .dma_fifo_clear, .dma_fifo_flush, .bus_fifo_clear
);

// file: verif/sdil_irq_ctrl_tb_top.sv
// Purpose: self-checking bench of the interrupt controller
// Assumes: host model drives the register port, bench drives the core side
// Notes:   a table covers fatal and masking classes, hand tests the rest
`timescale 1ns/1ns
module sdil_irq_ctrl_tb_top
   import sdil_pkg::*;
   ;
   typedef struct packed {
      logic [7:0] evt;
      logic [7:0] mask;
      logic       tgt;
      logic       halt;
      logic       irqn;
      logic [7:0] sum;
   } sdil_row_t;

   logic       clk_sys, resetn, on_fly_evt, script_running, bus_receiving, dma_fifo_empty;
   logic [7:0] bus_evt_a, bus_evt_b, reg_addr, reg_wdata, reg_rdata, d;
   logic [6:0] dma_evt;
   logic       reg_wr, reg_rd, irq_n, script_halt, dma_fifo_drain;
   logic       dma_fifo_clear, dma_fifo_flush, bus_fifo_clear;
   int         miscompares, checks_done, n;
   sdil_row_t  rows [8] = '{
      '{8'h40, 8'h00, 1'b0, 1'b0, 1'b1, 8'h00}, '{8'h40, 8'h40, 1'b0, 1'b1, 1'b0, 8'h02},
      '{8'h20, 8'h00, 1'b0, 1'b0, 1'b1, 8'h00}, '{8'h10, 8'h10, 1'b0, 1'b1, 1'b0, 8'h02},
      '{8'h80, 8'h00, 1'b1, 1'b0, 1'b1, 8'h00}, '{8'h10, 8'h00, 1'b1, 1'b1, 1'b1, 8'h02},
      '{8'h80, 8'h00, 1'b0, 1'b1, 1'b1, 8'h02}, '{8'h01, 8'h01, 1'b0, 1'b1, 1'b0, 8'h02}};
   logic [7:0] zero_regs [6] = '{8'h00, 8'h03, 8'h04, 8'h05, 8'h06, 8'h09};

   sdil_irq_ctrl uut (.clk_sys, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .bus_evt_a, .bus_evt_b, .dma_evt, .on_fly_evt, .script_running, .bus_receiving,
      .dma_fifo_empty, .irq_n, .script_halt, .dma_fifo_drain, .dma_fifo_clear,
      .dma_fifo_flush, .bus_fifo_clear);
   sdil_host_model host (.clk_sys, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);

   // ****************************************
   // helpers
   // ****************************************
   task automatic chk8(input logic [7:0] g, input logic [7:0] e, input string m);
      checks_done++;
      if (g !== e) begin
         miscompares++;
         $display("BAD %0t %s got %h exp %h", $time, m, g, e);
      end
   endtask : chk8
   task automatic chk1(input logic g, input logic e, input string m);
      chk8({7'h00, g}, {7'h00, e}, m);
   endtask : chk1
   task automatic rdc(input logic [7:0] a, input logic [7:0] e, input string m);
      host.rd(a, d);
      chk8(d, e, m);
   endtask : rdc
   task automatic tick(input int c);
      repeat (c) @(posedge clk_sys);
      #1;
   endtask : tick
   task automatic pulse(input logic [7:0] a, input logic [7:0] b, input logic [6:0] m);
      @(posedge clk_sys);
      bus_evt_a <= a;
      bus_evt_b <= b;
      dma_evt   <= m;
      @(posedge clk_sys);
      bus_evt_a <= 8'h00;
      bus_evt_b <= 8'h00;
      dma_evt   <= 7'h00;
   endtask : pulse
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : end_of_test

   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end

   initial begin
      repeat (20000) @(posedge clk_sys);
      miscompares++;
      $display("BAD %0t watchdog expired", $time);
      end_of_test();
   end

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      {resetn, on_fly_evt, script_running, bus_receiving} = 4'h0;
      {bus_evt_a, bus_evt_b, dma_evt} = 23'h0;
      dma_fifo_empty = 1'b1;
      repeat (2) @(posedge clk_sys);
      resetn <= 1'b1;
      #1 chk1(irq_n, 1'b1, "irq reset");
      foreach (zero_regs[i]) rdc(zero_regs[i], 8'h00, "reset value");
      $display("test reset done");
      foreach (rows[i]) begin
         host.wr(SDIL_OFS_MASK_A, rows[i].mask);
         host.wr(SDIL_OFS_MODE, {7'h00, rows[i].tgt});
         pulse(rows[i].evt, 8'h00, 7'h00);
         #1 chk1(script_halt, rows[i].halt, "halt");
         tick(1);
         chk1(irq_n, rows[i].irqn, "irq");
         rdc(SDIL_OFS_SUMMARY, rows[i].sum, "summary");
         rdc(SDIL_OFS_CAUSE_A, rows[i].evt, "cause a");
         rdc(SDIL_OFS_SUMMARY, 8'h00, "summary clear");
         chk1(irq_n, 1'b1, "irq off");
      end
      $display("test table done");
      @(posedge clk_sys) dma_fifo_empty <= 1'b0;
      host.wr(SDIL_OFS_DMA_MASK, 8'h01);
      host.wr(SDIL_OFS_MASK_B, 8'h01);
      pulse(8'h00, 8'h01, 7'h01);
      tick(1);
      chk1(irq_n, 1'b0, "irq both");
      host.service(d);
      chk8(d, 8'h03, "both pending");
      rdc(SDIL_OFS_SUMMARY, 8'h02, "dma read out");
      @(posedge clk_sys) dma_fifo_empty <= 1'b1;
      rdc(SDIL_OFS_DMA_CAUSE, 8'h80, "empty flag");
      rdc(SDIL_OFS_DMA_CAUSE, 8'h80, "empty kept");
      rdc(SDIL_OFS_CAUSE_B, 8'h01, "cause b");
      rdc(SDIL_OFS_SUMMARY, 8'h00, "both clear");
      $display("test both done");
      host.wr(SDIL_OFS_DMA_TEST, 8'h0C);
      #1 chk1(dma_fifo_clear, 1'b1, "dma clear");
      chk1(dma_fifo_flush, 1'b1, "dma flush");
      host.wr(SDIL_OFS_BUS_TEST, 8'h02);
      #1 chk1(bus_fifo_clear, 1'b1, "bus clear");
      rdc(SDIL_OFS_DMA_TEST, 8'h00, "test reg reads 0");
      $display("test fifo done");
      host.wr(SDIL_OFS_MASK_A, 8'h03);
      pulse(8'h01, 8'h00, 7'h00);
      pulse(8'h02, 8'h00, 7'h00);
      rdc(SDIL_OFS_CAUSE_A, 8'h01, "first level");
      tick(2);
      rdc(SDIL_OFS_SUMMARY, 8'h02, "promoted");
      rdc(SDIL_OFS_CAUSE_A, 8'h02, "second level");
      $display("test stack done");
      @(posedge clk_sys) on_fly_evt <= 1'b1;
      @(posedge clk_sys) on_fly_evt <= 1'b0;
      host.service(d);
      chk8(d, 8'h04, "on fly seen");
      rdc(SDIL_OFS_SUMMARY, 8'h00, "on fly clear");
      $display("test on_fly done");
      @(posedge clk_sys) script_running <= 1'b1;
      host.wr(SDIL_OFS_MASK_A, 8'hFF);
      rdc(SDIL_OFS_MASK_A, 8'h00, "refused read");
      rdc(SDIL_OFS_SUMMARY, 8'h00, "summary open");
      @(posedge clk_sys) script_running <= 1'b0;
      rdc(SDIL_OFS_MASK_A, 8'h03, "write ignored");
      $display("test running done");
      @(posedge clk_sys) bus_receiving <= 1'b1;
      dma_fifo_empty <= 1'b0;
      pulse(8'h00, 8'h01, 7'h00);
      tick(1);
      chk1(dma_fifo_drain, 1'b1, "drain");
      rdc(SDIL_OFS_SUMMARY, 8'h00, "held");
      @(posedge clk_sys) dma_fifo_empty <= 1'b1;
      n = 0;
      while (dma_fifo_drain !== 1'b0 && n < 8) begin
         @(posedge clk_sys);
         n++;
      end
      chk1(dma_fifo_drain, 1'b0, "drain ended");
      tick(2);
      rdc(SDIL_OFS_SUMMARY, 8'h02, "posted");
      chk1(irq_n, 1'b0, "irq posted");
      rdc(SDIL_OFS_CAUSE_B, 8'h01, "drain cause");
      @(posedge clk_sys) bus_receiving <= 1'b0;
      $display("test drain done");
      pulse(8'h01, 8'h00, 7'h00);
      tick(1);
      chk1(irq_n, 1'b0, "irq before reset");
      @(posedge clk_sys) resetn <= 1'b0;
      repeat (2) @(posedge clk_sys);
      resetn <= 1'b1;
      #1 chk1(irq_n, 1'b1, "irq after reset");
      rdc(SDIL_OFS_SUMMARY, 8'h00, "summary after reset");
      rdc(SDIL_OFS_MASK_A, 8'h00, "mask after reset");
      rdc(SDIL_OFS_CAUSE_A, 8'h00, "cause after reset");
      $display("test mid reset done");
      end_of_test();
   end
endmodule : sdil_irq_ctrl_tb_top
